/* rsh_session.v */
// resource data exchange session handler, upstream side
`include "rsh_defs.vh"
module rsh_session (
	input wire mclk,
	input wire arst_n,
	input wire want_info,
	output wire request_busy,
	output reg resource_request_msg,
	input wire msg_valid,
	input wire [2:0] msg_kind,
	input wire [9:0] announced_msg_count,
	input wire grant_is_fic,
	input wire [12:0] grant_value,
	output reg session_error_msg,
	output reg [31:0] err_cause,
	output reg [2:0] err_code,
	output reg session_open,
	output reg session_done,
	output reg outside_flag,
	output wire [9:0] capacity_units,
	output wire [12:0] max_bytes_per_second,
	output wire msc_valid,
	output wire fic_valid
);

// ----------------------------------------
// states
// ----------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_WAIT = 3'b010;
localparam ST_OPEN = 3'b100;

reg [2:0] state;
reg [2:0] next_state;
reg [9:0] expected;
reg [9:0] received;
reg [2:0] next_err_code;
reg [31:0] next_err_cause;
reg raise_err;

// ----------------------------------------
// message decoding
// ----------------------------------------
// one decoder so every check sees the same qualified strobe
function kind_is;
	input valid;
	input [2:0] kind;
	input [2:0] want;
	begin
		kind_is = valid && (kind == want);
	end
endfunction

// ascii cause word that goes with an error code number
function [31:0] cause_of;
	input [2:0] code;
	begin
		case (code)
			`RSH_ERR_COUNT: cause_of = `RSH_CAUSE_COUNT;
			`RSH_ERR_DUP: cause_of = `RSH_CAUSE_DUP;
			`RSH_ERR_RANGE: cause_of = `RSH_CAUSE_RANGE;
			default: cause_of = `RSH_CAUSE_SEQ;
		endcase
	end
endfunction

wire msc_seen;
wire fic_seen;
wire is_open = kind_is(msg_valid, msg_kind, `RSH_KIND_OPEN);
wire is_close = kind_is(msg_valid, msg_kind, `RSH_KIND_CLOSE);
wire is_grant = kind_is(msg_valid, msg_kind, `RSH_KIND_GRANT);
wire is_other = kind_is(msg_valid, msg_kind, `RSH_KIND_OTHER);
wire in_sess = (state == ST_OPEN);

// ----------------------------------------
// checks
// ----------------------------------------
function grant_ok;
	input fast_info_channel;
	input [12:0] v;
	begin
		if (fast_info_channel)
			grant_ok = (v <= `RSH_FIC_RATE_MAX);
		else
			grant_ok = (v <= {3'h0, `RSH_CAP_UNITS_MAX});
	end
endfunction

wire counted = in_sess && (is_grant || is_other);
// excess message aborts at once, before it can be stored
wire over = counted && (received == expected);
wire dup = in_sess && is_grant &&
	(grant_is_fic ? fic_seen : msc_seen);
wire bad_range = in_sess && is_grant &&
	!grant_ok(grant_is_fic, grant_value);
wire bad_count = in_sess && is_close && (received != expected);
wire bad_open = is_open && (announced_msg_count > `RSH_COUNT_MAX);
wire abort = over || dup || bad_range || bad_count || bad_open;
wire stray = !in_sess && (is_grant || is_other || is_close);

assign request_busy = (state != ST_IDLE);

// ----------------------------------------
// session state
// ----------------------------------------

always @*
begin
	next_state = state;
	case (state)
		ST_IDLE:
			if (want_info)
				next_state = ST_WAIT;
		ST_WAIT:
			if (is_open && !bad_open)
				next_state = ST_OPEN;
			else if (bad_open)
				next_state = ST_IDLE;
		ST_OPEN:
			if (abort || is_close)
				next_state = ST_IDLE;
		default:
			next_state = ST_IDLE;
	endcase
end

// ----------------------------------------
// error selection
// ----------------------------------------
// only the first cause found is reported
always @*
begin
	raise_err = (in_sess && abort) || (state == ST_WAIT && bad_open);
	if (over || bad_count)
		next_err_code = `RSH_ERR_COUNT;
	else if (dup)
		next_err_code = `RSH_ERR_DUP;
	else
		next_err_code = `RSH_ERR_RANGE;
	next_err_cause = cause_of(next_err_code);
end

// ----------------------------------------
// session bookkeeping
// ----------------------------------------
always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		state <= ST_IDLE;
		expected <= 10'h000;
		received <= 10'h000;
		resource_request_msg <= 1'b0;
		session_error_msg <= 1'b0;
		err_cause <= 32'h00000000;
		err_code <= `RSH_ERR_NONE;
		session_open <= 1'b0;
		session_done <= 1'b0;
		outside_flag <= 1'b0;
	end
	else
	begin
		state <= next_state;
		resource_request_msg <= (state == ST_IDLE) && want_info;
		session_error_msg <= 1'b0;
		session_done <= 1'b0;
		outside_flag <= stray;
		session_open <= (next_state == ST_OPEN);
		if (state == ST_WAIT && is_open)
		begin
			expected <= announced_msg_count;
			received <= 10'h000;
		end
		else if (counted && !over)
			received <= received + 10'h001;
		if (in_sess && is_close && !bad_count)
			session_done <= 1'b1;
		if (raise_err)
		begin
			session_error_msg <= 1'b1;
			err_cause <= next_err_cause;
			err_code <= next_err_code;
		end
		else if (stray)
			err_code <= `RSH_ERR_OUTSIDE;
	end
end

// ----------------------------------------
// grant store
// ----------------------------------------
// grants accepted only when checks pass; seen flags cleared per session, stored values kept
rsh_grant_store u_store (
	.mclk(mclk),
	.arst_n(arst_n),
	.clear(state == ST_WAIT && is_open),
	.wr_msc(in_sess && is_grant && !grant_is_fic && !abort),
	.wr_fic(in_sess && is_grant && grant_is_fic && !abort),
	.wr_value(grant_value),
	.msc_units(capacity_units),
	.fic_rate(max_bytes_per_second),
	.msc_seen(msc_seen),
	.fic_seen(fic_seen)
);

// ----------------------------------------
// grant outputs
// ----------------------------------------
assign msc_valid = msc_seen;
assign fic_valid = fic_seen;

endmodule // rsh_session

/* rsh_defs.vh */
// constants for the resource session handler
`ifndef RSH_DEFS_VH
`define RSH_DEFS_VH
// ----------------------------------------
// message kinds on the received message port
// ----------------------------------------
`define RSH_KIND_OPEN 3'h1
`define RSH_KIND_CLOSE 3'h2
`define RSH_KIND_GRANT 3'h3
`define RSH_KIND_OTHER 3'h4
// ----------------------------------------
// field limits
// ----------------------------------------
`define RSH_COUNT_MAX 10'h3e7
`define RSH_CAP_UNITS_MAX 10'h360
`define RSH_FIC_RATE_MAX 13'h14d6
// ----------------------------------------
// error causes, four ascii characters each
// ----------------------------------------
`define RSH_CAUSE_COUNT 32'h4e4d5347
`define RSH_CAUSE_RANGE 32'h52414e47
`define RSH_CAUSE_DUP 32'h44555043
`define RSH_CAUSE_SEQ 32'h53455155
// ----------------------------------------
// error code numbers on err_code
// ----------------------------------------
`define RSH_ERR_NONE 3'h0
`define RSH_ERR_COUNT 3'h1
`define RSH_ERR_RANGE 3'h2
`define RSH_ERR_DUP 3'h3
`define RSH_ERR_OUTSIDE 3'h4
`endif

/* rsh_grant_store.v */
// holds the last accepted main and fast channel grants, from any session
module rsh_grant_store (
	input wire mclk,
	input wire arst_n,
	input wire clear,
	input wire wr_msc,
	input wire wr_fic,
	input wire [12:0] wr_value,
	output reg [9:0] msc_units,
	output reg [12:0] fic_rate,
	output reg msc_seen,
	output reg fic_seen
);

always @(posedge mclk or negedge arst_n)
begin
	if (!arst_n)
	begin
		msc_units <= 10'h000;
		fic_rate <= 13'h0000;
		msc_seen <= 1'b0;
		fic_seen <= 1'b0;
	end
	else if (clear)
	begin
		msc_seen <= 1'b0;
		fic_seen <= 1'b0;
	end
	else
	begin
		if (wr_msc)
		begin
			msc_units <= wr_value[9:0];
			msc_seen <= 1'b1;
		end
		if (wr_fic)
		begin
			fic_rate <= wr_value;
			fic_seen <= 1'b1;
		end
	end
end

endmodule // rsh_grant_store

/* rsh_far_end.sv */
// model of the downstream entity feeding the session handler
module rsh_far_end (
	input wire logic mclk,
	input wire logic req,
	input wire logic [9:0] n_msg,
	input wire logic [9:0] n_send,
	input wire logic [12:0] u,
	input wire logic [3:0] gap,
	input wire logic one_ch,
	output logic v,
	output logic [2:0] k,
	output logic [9:0] c,
	output logic f,
	output logic [12:0] g
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{v, k, c, f, g} = 0;
		forever
		begin
			@(negedge mclk);
			if (req)
			begin
				repeat (gap) @(negedge mclk);
				{v, k, c} = {1'b1, 3'h1, n_msg};
				for (int i = 0; i < n_send; i++)
				begin
					@(negedge mclk);
					// first two are grants, one per channel unless one_ch
					k = i < 2 ? 3'h3 : 3'h4;
					f = one_ch ? 1'b0 : i[0];
					g = u;
				end
				@(negedge mclk);
				k = 3'h2;
				@(negedge mclk);
				// released lines must not look valid
				{v, k, g} = {1'b0, ~k, ~g};
			end
		end
	end
endmodule // rsh_far_end

/* rsh_session_asserts.sv */
// port assertions for the session handler
module rsh_chk (
	input wire mclk,
	input wire arst_n,
	input wire want_info,
	input wire request_busy,
	input wire resource_request_msg,
	input wire msg_valid,
	input wire [2:0] msg_kind,
	input wire [9:0] announced_msg_count,
	input wire session_error_msg,
	input wire [31:0] err_cause,
	input wire [2:0] err_code,
	input wire session_open,
	input wire session_done,
	input wire outside_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_open;
		request_busy && !session_open && msg_valid && msg_kind == 3'h1;
	endsequence
	a_req_taken: assert property (want_info && !request_busy |=>
		resource_request_msg) else $error("no request");
	a_req_once: assert property (resource_request_msg |=>
		!resource_request_msg) else $error("long request");
	a_open_ok: assert property (s_open ##0 announced_msg_count <= 10'h3e7
		|=> session_open) else $error("open lost");
	a_range_err: assert property (s_open ##0 announced_msg_count > 10'h3e7
		|=> session_error_msg && err_code == 3'h2) else $error("no range");
	a_err_abort: assert property (session_error_msg |->
		!session_open && !request_busy) else $error("no abort");
	a_count_cause: assert property (session_error_msg && err_code == 3'h1
		|-> err_cause == 32'h4e4d5347) else $error("bad cause");
	a_dup_cause: assert property (session_error_msg && err_code == 3'h3
		|-> err_cause == 32'h44555043) else $error("bad dup cause");
	a_done_close: assert property (session_done |->
		$past(msg_valid && msg_kind == 3'h2)) else $error("stray done");
	a_stray_flag: assert property (!request_busy && msg_valid &&
		msg_kind inside {3'h2, 3'h3, 3'h4} |=> outside_flag) else $error("no flag");
endmodule // rsh_chk
bind rsh_session rsh_chk chk (.*);

/* tb_resource_session_handler.sv */
// self-checking bench for the session handler
`include "rsh_defs.vh"
module tb_resource_session_handler;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, arst_n = 0, want_info = 0, request_busy, msg_valid;
	logic resource_request_msg, grant_is_fic, session_error_msg, session_open;
	logic session_done, outside_flag, msc_valid, fic_valid;
	logic [2:0] msg_kind, err_code;
	logic [9:0] announced_msg_count, capacity_units, n_msg, n_send, n;
	logic [12:0] grant_value, max_bytes_per_second, u;
	logic [31:0] err_cause;
	logic [3:0] gap;
	logic one_ch = 0;
	int fail_count, n_compared, w, seen_out;
	always #5 mclk = ~mclk;
	rsh_session DUT (.*);
	rsh_far_end far (.mclk(mclk), .req(resource_request_msg), .n_msg(n_msg),
		.n_send(n_send), .u(u), .gap(gap), .one_ch(one_ch), .v(msg_valid),
		.k(msg_kind),
		.c(announced_msg_count), .f(grant_is_fic), .g(grant_value));
	always @(posedge mclk) if (outside_flag) seen_out++;
	task chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task run(input logic [9:0] a, s, input logic [1:0] m);
		{n_msg, n_send} = {a, s};
		if (m[0])
			u = 13'($urandom_range(5334, 865));
		else
			u = 13'($urandom_range(864));
		one_ch = m[1];
		gap = 4'($urandom_range(3));
		want_info = 1;
		@(negedge mclk);
		want_info = 0;
		for (w = 0; w < 900 && !session_done && !session_error_msg; w++)
			@(negedge mclk);
	endtask
	task errc(input logic [31:0] ca, input logic [2:0] co);
		chk("err", session_error_msg, 1);
		chk("cause", err_cause, ca);
		chk("code", err_code, co);
		repeat (12) @(negedge mclk);
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		give_verdict;
	end
	initial
	begin
		void'($urandom(32'he999));
		repeat (12) @(negedge mclk);
		arst_n = 1;
		for (int i = 0; i < 5; i++)
		begin
			n = i == 0 ? 10'h0 : 10'($urandom_range(2, 9));
			run(n, n, 2'h0);
			chk("done", session_done, 1);
			chk("mscv", msc_valid, i > 0);
			chk("ficv", fic_valid, i > 0);
			chk("units", capacity_units, i > 0 ? u[9:0] : 10'h0);
			chk("rate", max_bytes_per_second, i > 0 ? u : 13'h0);
			repeat (4) @(negedge mclk);
		end
		run(10'h2, 10'h3, 2'h0);
		errc(`RSH_CAUSE_COUNT, `RSH_ERR_COUNT);
		run(10'h3, 10'h1, 2'h0);
		errc(`RSH_CAUSE_COUNT, `RSH_ERR_COUNT);
		run(10'h3, 10'h2, 2'h1);
		chk("mscv", msc_valid, 0);
		errc(`RSH_CAUSE_RANGE, `RSH_ERR_RANGE);
		run(10'h3, 10'h3, 2'h2);
		chk("units", capacity_units, u[9:0]);
		errc(`RSH_CAUSE_DUP, `RSH_ERR_DUP);
		run(10'h3e8, 10'h1, 2'h0);
		errc(`RSH_CAUSE_RANGE, `RSH_ERR_RANGE);
		chk("code", err_code, `RSH_ERR_OUTSIDE);
		chk("stray", seen_out > 0, 1);
		give_verdict;
	end
endmodule // tb_resource_session_handler
